// ### verilog/tsk_task_unit.sv
/*
 Task register and task state block engine: saves the outgoing context,
 links, loads the incoming context, and serves load/store selector ops.
 Assumes a word memory port that holds a request until acknowledged and
 a context source that stays stable while an operation runs.
*/
// Contract
// (R1) Save eight general registers at bytes 40 through 68 of the old block.
// (R2) Save six segment selectors in 32-bit slots at bytes 72 through 92.
// (R3) Save instruction pointer at byte 32 and flags at byte 36.
// (R4) Write old selector at byte 0 of new block only for call/interrupt.
// (R5) Read, never write, local table selector (96) and page root (28).
// (R6) Privilege stack pointers at bytes 4 to 24 are never written.
// (R7) Trap bit 0 of byte 100 in new block raises a debug exception.
// (R8) I/O map base is a 16-bit offset from the block start.
// (R9) Block bytes 0 to 103 are addressed as base plus offset, no retranslation.
// (R10) Local-table selector: protection fault for call/jump, block fault for return.
// (R11) Loading a task block selector into a segment register faults.
// (R12) Type 1001B is inactive, 1011B busy; type bit 1 is busy.
// (R13) Calling a busy task is rejected.
// (R14) Byte granular limit below 67H gives an invalid block fault.
// (R15) No larger limit check on switch; limit checked on I/O bitmap access.
// (R16) Call/jump allowed only when current privilege <= descriptor privilege.
// (R17) Task register holds 16-bit selector, 32-bit base, 16-bit limit, attributes.
// (R18) Cached descriptor is hidden and used to address the current block.
// (R19) Load op fills selector then cached part; privilege 0 only.
// (R20) Store op copies the visible selector at any privilege.
// (R21) Task register updates on every task switch.
// (R22) Reset clears selector and base, limit becomes FFFFH.
`timescale 1ns/1ps
module tsk_task_unit
#(
   parameter int ADDR_W = 32
)
(
   // Clock and reset
   input  wire logic                 clk,
   input  wire logic                 nrst,
   // Operation request
   input  wire logic                 op_valid,
   input  wire tsk_pkg::tsk_op_e     op_kind,
   input  wire tsk_pkg::tsk_cause_e  op_cause,
   input  wire logic [15:0]          op_sel,
   input  wire logic [1:0]           current_privilege_level,
   input  wire logic [31:0]          gdt_base,
   // Outgoing context
   input  wire logic [31:0]          ctx_ip,
   input  wire logic [31:0]          ctx_flags,
   input  wire logic [255:0]         ctx_gpr,
   input  wire logic [95:0]          ctx_seg,
   // Memory port
   output logic                      mem_req,
   output logic                      mem_we,
   output logic [ADDR_W-1:0]         mem_addr,
   output logic [31:0]               mem_wdata,
   input  wire logic                 mem_ack,
   input  wire logic [31:0]          mem_rdata,
   // Incoming context stream
   output logic                      ld_valid,
   output logic [6:0]                ld_off,
   output logic [31:0]               ld_data,
   // Results
   output logic                      busy,
   output logic                      done,
   output logic                      fault_gp,
   output logic                      fault_ts,
   output logic                      debug_trap,
   output logic [15:0]               store_sel,
   output logic [15:0]               current_task_selector,
   output logic [15:0]               ldt_sel,
   output logic [31:0]               page_root,
   // I/O bitmap limit check
   input  wire logic                 io_req,
   input  wire logic [15:0]          io_port,
   output logic                      io_ack,
   output logic                      io_deny
);
   typedef enum logic [6:0] {
      ST_IDLE = 7'h01,
      ST_DLO  = 7'h02,
      ST_DHI  = 7'h04,
      ST_CHK  = 7'h08,
      ST_SAVE = 7'h10,
      ST_LINK = 7'h20,
      ST_LOAD = 7'h40
   } tsk_state_e;

   if (ADDR_W != 32)
   begin : g_chk
      $error("tsk_task_unit supports ADDR_W of 32 only");
   end

   tsk_state_e          st_r;
   tsk_pkg::tsk_op_e    op_r;
   tsk_pkg::tsk_cause_e cause_r;
   logic [15:0]         new_sel_r;
   logic [31:0]         dlo_r;
   logic [31:0]         dhi_r;
   logic [4:0]          cnt_r;
   logic [15:0]         tr_sel_r;
   logic [31:0]         tr_base_r;
   logic [15:0]         tr_limit_r;
   logic [11:0]         tr_attr_r;
   logic [15:0]         iomap_r;
   logic                chk_gp;
   logic                chk_ts;
   logic [31:0]         chk_base;
   logic [15:0]         chk_limit;
   logic [31:0]         new_base_r;
   logic                link_needed;
   logic                last_word;
   logic                idle_fault;

   tsk_desc_check u_chk
   (
      .dlo   (dlo_r),
      .dhi   (dhi_r),
      .op    (op_r),
      .cause (cause_r),
      .current_privilege_level   (current_privilege_level),
      .gp    (chk_gp),
      .ts    (chk_ts),
      .base  (chk_base),
      .limit (chk_limit)
   );

   function automatic logic [31:0] save_word(input logic [4:0] k);
      logic [31:0] w;
      w = 32'h0000_0000;
      if (k == 5'h00)
         w = ctx_ip;
      else if (k == 5'h01)
         w = ctx_flags;
      else if (k < tsk_pkg::SEG_FIRST_IX)
         w = ctx_gpr[32*(k-tsk_pkg::GPR_FIRST_IX) +: 32];
      else
         w = {16'h0000, ctx_seg[16*(k-tsk_pkg::SEG_FIRST_IX) +: 16]};
      return w;
   endfunction

   // Block address of a word index, counted from a start offset
   function automatic logic [31:0] blk_addr(input logic [31:0] b,
                                            input logic [6:0] start,
                                            input logic [4:0] k);
      return b + {25'h000_0000, start + 7'({k, 2'b00})}; // R9
   endfunction

   assign link_needed = (cause_r == tsk_pkg::CS_CALL) ||
                        (cause_r == tsk_pkg::CS_INTX); // R4
   assign last_word = mem_ack &&
      (((st_r == ST_SAVE) && (cnt_r == tsk_pkg::SAVE_WORDS - 5'h01)) ||
       ((st_r == ST_LOAD) && (cnt_r == tsk_pkg::LOAD_WORDS - 5'h01)));

   // Sequencer and memory port
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         st_r <= ST_IDLE;
         op_r <= tsk_pkg::OP_SWITCH;
         cause_r <= tsk_pkg::CS_CALL;
         new_sel_r <= 16'h0000;
         dlo_r <= 32'h0000_0000;
         dhi_r <= 32'h0000_0000;
         new_base_r <= 32'h0000_0000;
         cnt_r <= 5'h00;
         mem_req <= 1'b0;
         mem_we <= 1'b0;
         mem_addr <= 32'h0000_0000;
         mem_wdata <= 32'h0000_0000;
      end
      else
      begin
         unique case (st_r)
            ST_IDLE:
               if (op_valid && op_kind != tsk_pkg::OP_STORE && !idle_fault)
               begin
                  op_r <= op_kind;
                  cause_r <= op_cause;
                  new_sel_r <= op_sel;
                  mem_req <= 1'b1;
                  mem_we <= 1'b0;
                  mem_addr <= gdt_base + {16'h0000, op_sel[15:tsk_pkg::SEL_IX_LSB], 3'b000};
                  st_r <= ST_DLO;
               end
            ST_DLO:
               if (mem_ack)
               begin
                  dlo_r <= mem_rdata;
                  mem_addr <= mem_addr + tsk_pkg::DESC_STEP;
                  st_r <= ST_DHI;
               end
            ST_DHI:
               if (mem_ack)
               begin
                  dhi_r <= mem_rdata;
                  mem_req <= 1'b0;
                  st_r <= ST_CHK;
               end
            ST_CHK:
               if (chk_gp || chk_ts || op_r != tsk_pkg::OP_SWITCH)
                  st_r <= ST_IDLE;
               else
               begin
                  new_base_r <= chk_base;
                  cnt_r <= 5'h00;
                  mem_req <= 1'b1;
                  mem_we <= 1'b1;
                  mem_addr <= blk_addr(tr_base_r, tsk_pkg::OFF_IP, 5'h00); // R18 R6
                  mem_wdata <= save_word(5'h00); // R3
                  st_r <= ST_SAVE;
               end
            ST_SAVE:
               if (mem_ack)
               begin
                  cnt_r <= cnt_r + 5'h01;
                  mem_addr <= blk_addr(tr_base_r, tsk_pkg::OFF_IP, cnt_r + 5'h01);
                  mem_wdata <= save_word(cnt_r + 5'h01); // R1 R2
                  if (last_word)
                  begin
                     cnt_r <= 5'h00;
                     if (link_needed)
                     begin
                        mem_addr <= blk_addr(new_base_r, tsk_pkg::OFF_LINK, 5'h00);
                        mem_wdata <= {16'h0000, tr_sel_r}; // R4
                        st_r <= ST_LINK;
                     end
                     else
                     begin
                        mem_we <= 1'b0;
                        mem_addr <= blk_addr(new_base_r, tsk_pkg::OFF_PDIR, 5'h00);
                        st_r <= ST_LOAD;
                     end
                  end
               end
            ST_LINK:
               if (mem_ack)
               begin
                  mem_we <= 1'b0;
                  mem_addr <= blk_addr(new_base_r, tsk_pkg::OFF_PDIR, 5'h00);
                  st_r <= ST_LOAD;
               end
            ST_LOAD:
               if (mem_ack)
               begin
                  cnt_r <= cnt_r + 5'h01;
                  mem_addr <= blk_addr(new_base_r, tsk_pkg::OFF_PDIR, cnt_r + 5'h01);
                  if (last_word)
                  begin
                     mem_req <= 1'b0;
                     st_r <= ST_IDLE;
                  end
               end
         endcase
      end
   end

   // Faults decided before any memory access
   assign idle_fault = (op_kind == tsk_pkg::OP_LOAD && current_privilege_level != 2'b00) ||
                       (op_sel[tsk_pkg::TI_BIT] && op_kind != tsk_pkg::OP_SEGLD);

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         fault_gp <= 1'b0;
         fault_ts <= 1'b0;
      end
      else
      begin
         fault_gp <= 1'b0;
         fault_ts <= 1'b0;
         if (st_r == ST_IDLE && op_valid && op_kind != tsk_pkg::OP_STORE && idle_fault)
         begin
            if (op_kind == tsk_pkg::OP_SWITCH && op_cause == tsk_pkg::CS_INTERRUPT_RETURN_OP)
               fault_ts <= 1'b1; // R10
            else
               fault_gp <= 1'b1; // R10 R19
         end
         else if (st_r == ST_CHK)
         begin
            fault_gp <= chk_gp; // R11 R13 R16
            fault_ts <= chk_ts; // R14
         end
      end
   end

   // Task register, visible and hidden parts
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         tr_sel_r <= 16'h0000; // R22
         tr_base_r <= 32'h0000_0000;
         tr_limit_r <= tsk_pkg::RESET_LIMIT;
         tr_attr_r <= 12'h000;
      end
      else if ((st_r == ST_CHK && op_r == tsk_pkg::OP_LOAD && !chk_gp) || last_word &&
               st_r == ST_LOAD)
      begin
         tr_sel_r <= new_sel_r; // R17 R19 R21
         tr_base_r <= (st_r == ST_CHK) ? chk_base : new_base_r;
         tr_limit_r <= chk_limit;
         tr_attr_r <= {dhi_r[23:20], dhi_r[15:8]};
      end
   end

   // Incoming context capture and stream
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         ld_valid <= 1'b0;
         ld_off <= 7'h00;
         ld_data <= 32'h0000_0000;
         ldt_sel <= 16'h0000;
         page_root <= 32'h0000_0000;
         iomap_r <= 16'h0000;
      end
      else
      begin
         ld_valid <= st_r == ST_LOAD && mem_ack;
         if (st_r == ST_LOAD && mem_ack)
         begin
            ld_off <= tsk_pkg::OFF_PDIR + 7'({cnt_r, 2'b00});
            ld_data <= mem_rdata;
            if (cnt_r == 5'h00)
               page_root <= mem_rdata; // R5
            if (last_word)
            begin
               iomap_r <= mem_rdata[tsk_pkg::IOMAP_LSB +: 16]; // R8
            end
            if (cnt_r == tsk_pkg::LOAD_WORDS - 5'h02)
               ldt_sel <= mem_rdata[15:0]; // R5
         end
      end
   end

   // Completion, store op and status
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         done <= 1'b0;
         debug_trap <= 1'b0;
         store_sel <= 16'h0000;
         busy <= 1'b0;
      end
      else
      begin
         done <= (st_r == ST_IDLE && op_valid && op_kind == tsk_pkg::OP_STORE) ||
                 (st_r == ST_CHK && !chk_gp && !chk_ts && op_r != tsk_pkg::OP_SWITCH) ||
                 (st_r == ST_LOAD && last_word);
         debug_trap <= st_r == ST_LOAD && last_word && mem_rdata[tsk_pkg::TRAP_BIT]; // R7
         if (st_r == ST_IDLE && op_valid && op_kind == tsk_pkg::OP_STORE)
            store_sel <= tr_sel_r; // R20
         // Follows the next state, so busy is already low with done or a fault
         busy <= (st_r == ST_IDLE) ?
                 (op_valid && op_kind != tsk_pkg::OP_STORE && !idle_fault) :
                 !((st_r == ST_CHK && (chk_gp || chk_ts || op_r != tsk_pkg::OP_SWITCH)) ||
                   (st_r == ST_LOAD && last_word));
      end
   end

   // I/O bitmap byte must lie inside the block limit
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         io_ack <= 1'b0;
         io_deny <= 1'b0;
      end
      else
      begin
         io_ack <= io_req;
         if (io_req)
            io_deny <= (17'(iomap_r) + 17'(io_port[15:3])) > 17'(tr_limit_r); // R15
      end
   end

   assign current_task_selector = tr_sel_r;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   sequence s_ltr_low;
      st_r == ST_IDLE && op_valid && op_kind == tsk_pkg::OP_LOAD && current_privilege_level != 2'b00;
   endsequence
   sequence s_last_load;
      st_r == ST_LOAD && last_word;
   endsequence

   a_tr_reset_value: assert property ($rose(nrst) |-> tr_limit_r == tsk_pkg::RESET_LIMIT &&
      tr_base_r == 32'h0000_0000) else $error("task register reset value wrong"); // R22
   a_ltr_priv_zero: assert property (s_ltr_low |=> fault_gp && st_r == ST_IDLE)
      else $error("load op above privilege 0 not refused"); // R19
   a_save_gpr_slot: assert property (st_r == ST_SAVE && mem_req && cnt_r == 5'h09 |->
      mem_addr == tr_base_r + 32'(tsk_pkg::OFF_GPR_LAST) && mem_wdata == ctx_gpr[255:224])
      else $error("last general register slot wrong"); // R1
   a_save_seg_slot: assert property (st_r == ST_SAVE && mem_req && cnt_r == 5'h0F |->
      mem_addr == tr_base_r + 32'(tsk_pkg::OFF_SEG_LAST) &&
      mem_wdata == {16'h0000, ctx_seg[95:80]}) else $error("segment slot wrong"); // R2
   a_save_ip_slot: assert property ($rose(st_r == ST_SAVE) |->
      mem_addr == tr_base_r + 32'(tsk_pkg::OFF_IP) && mem_wdata == ctx_ip && mem_we)
      else $error("instruction pointer slot wrong"); // R3
   a_link_cause: assert property (st_r == ST_LINK |-> link_needed &&
      mem_addr == new_base_r && mem_wdata[15:0] == tr_sel_r)
      else $error("link written for wrong cause"); // R4
   a_no_static_wr: assert property (mem_req && mem_we && st_r == ST_SAVE |->
      mem_addr >= tr_base_r + 32'(tsk_pkg::OFF_IP))
      else $error("static field written"); // R6
   a_trap_raise: assert property (s_last_load ##1 1'b1 |->
      debug_trap == $past(mem_rdata[0]) && done) else $error("trap bit ignored"); // R7
   a_ti_fault: assert property (st_r == ST_IDLE && op_valid &&
      op_kind == tsk_pkg::OP_SWITCH && op_sel[tsk_pkg::TI_BIT] |=>
      (fault_gp ^ fault_ts) && fault_ts == ($past(op_cause) == tsk_pkg::CS_INTERRUPT_RETURN_OP))
      else $error("local table selector fault wrong"); // R10
   a_tr_switch: assert property (s_last_load |=> tr_sel_r == $past(new_sel_r) &&
      tr_base_r == $past(new_base_r)) else $error("task register not updated"); // R21
   a_str_copy: assert property (st_r == ST_IDLE && op_valid &&
      op_kind == tsk_pkg::OP_STORE |=> done && store_sel == $past(tr_sel_r))
      else $error("store op result wrong"); // R20
endmodule

// ### verilog/tsk_pkg.sv
/*
 Constants for the task state unit: task state block layout, descriptor
 fields, operation and cause codes.
 Assumes 32-bit words and byte offsets within the task state block.
*/
package tsk_pkg;
   // Task state block byte offsets
   localparam logic [6:0] OFF_LINK     = 7'h00;
   localparam logic [6:0] OFF_PDIR     = 7'h1C;
   localparam logic [6:0] OFF_IP       = 7'h20;
   localparam logic [6:0] OFF_GPR_LAST = 7'h44;
   localparam logic [6:0] OFF_SEG      = 7'h48;
   localparam logic [6:0] OFF_SEG_LAST = 7'h5C;
   localparam logic [6:0] OFF_LDT      = 7'h60;
   localparam logic [6:0] OFF_TRAP     = 7'h64;
   localparam logic [6:0] WORD_STEP    = 7'h04;
   localparam logic [4:0] SAVE_WORDS   = 5'h10;
   localparam logic [4:0] LOAD_WORDS   = 5'h13;
   localparam logic [4:0] SEG_FIRST_IX = 5'h0A;
   localparam logic [4:0] GPR_FIRST_IX = 5'h02;
   localparam int         TRAP_BIT     = 0;
   localparam int         IOMAP_LSB    = 16;
   // Selector and descriptor fields
   localparam int         TI_BIT       = 2;
   localparam int         SEL_IX_LSB   = 3;
   localparam logic [3:0] TYPE_AVAIL   = 4'h9;
   localparam logic [3:0] TYPE_BUSY    = 4'hB;
   localparam int         BUSY_BIT     = 1;
   localparam logic [19:0] MIN_LIMIT   = 20'h0_0067;
   localparam logic [15:0] RESET_LIMIT = 16'hFFFF;
   localparam logic [31:0] DESC_STEP   = 32'h0000_0004;

   typedef enum logic [1:0] {
      OP_SWITCH = 2'h0,
      OP_LOAD   = 2'h1,
      OP_STORE  = 2'h2,
      OP_SEGLD  = 2'h3
   } tsk_op_e;

   typedef enum logic [1:0] {
      CS_CALL = 2'h0,
      CS_JMP  = 2'h1,
      CS_INTX = 2'h2,
      CS_INTERRUPT_RETURN_OP = 2'h3
   } tsk_cause_e;
endpackage

// ### verilog/tsk_desc_check.sv
/*
 Decodes a fetched descriptor pair and decides the fault for the pending
 operation. Purely combinational; the caller registers the result.
*/
`timescale 1ns/1ps
module tsk_desc_check
(
   // Fetched descriptor words
   input  wire logic [31:0]         dlo,
   input  wire logic [31:0]         dhi,
   // Pending operation
   input  wire tsk_pkg::tsk_op_e    op,
   input  wire tsk_pkg::tsk_cause_e cause,
   input  wire logic [1:0]          current_privilege_level,
   // Decision and decoded fields
   output logic                     gp,
   output logic                     ts,
   output logic [31:0]              base,
   output logic [15:0]              limit
);
   logic [3:0]  dtype;
   logic [19:0] lim20;
   logic        is_task_blk;
   logic        present;
   logic [1:0]  descriptor_privilege_level;
   logic        gran;

   always_comb
   begin
      dtype = dhi[11:8];
      lim20 = {dhi[19:16], dlo[15:0]};
      present = dhi[15];
      descriptor_privilege_level = dhi[14:13];
      gran = dhi[23];
      // Busy flag is bit 1 of the type; both codes share the rest
      is_task_blk = !dhi[12] && ((dtype == tsk_pkg::TYPE_AVAIL) ||
                                 (dtype == tsk_pkg::TYPE_BUSY)); // R12
      base = {dhi[31:24], dhi[7:0], dlo[31:16]};
      limit = lim20[15:0];
      gp = 1'b0;
      ts = 1'b0;
      unique case (op)
         tsk_pkg::OP_LOAD:
            gp = (dtype != tsk_pkg::TYPE_AVAIL) || dhi[12];
         tsk_pkg::OP_SEGLD:
            gp = is_task_blk; // R11
         tsk_pkg::OP_SWITCH:
         begin
            if (!is_task_blk)
               gp = 1'b1;
            else if (!present)
               ts = 1'b1;
            else if ((cause == tsk_pkg::CS_CALL || cause == tsk_pkg::CS_JMP) &&
                     (current_privilege_level > descriptor_privilege_level))
               gp = 1'b1; // R16
            else if (cause == tsk_pkg::CS_INTERRUPT_RETURN_OP && !dtype[tsk_pkg::BUSY_BIT])
               ts = 1'b1;
            else if (cause != tsk_pkg::CS_INTERRUPT_RETURN_OP && dtype[tsk_pkg::BUSY_BIT])
               gp = 1'b1; // R13
            else if (!gran && (lim20 < tsk_pkg::MIN_LIMIT))
               ts = 1'b1; // R14 R15
         end
         default:
         begin
            gp = 1'b0;
            ts = 1'b0;
         end
      endcase
   end
endmodule

// ### dv/tsk_mem_model.sv
/*
 Word memory standing behind the task unit: descriptor table and blocks.
 Assumes a requester that holds each word request until acknowledged.
*/
`timescale 1ns/1ps
module tsk_mem_model
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        nrst,
   // Stall cycles per word
   input  wire logic [3:0]  lat,
   // Word port
   input  wire logic        mem_req,
   input  wire logic        mem_we,
   input  wire logic [31:0] mem_addr,
   input  wire logic [31:0] mem_wdata,
   output logic             mem_ack,
   output logic [31:0]      mem_rdata
);
   logic [31:0] m [0:255];
   int          cnt;

   // Read data inverts every cycle between answers, so stale words look valid only on every second cycle
   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         mem_ack   <= 1'b0;
         cnt       <= 0;
         mem_rdata <= 32'h0000_0000;
      end
      else if (mem_req && !mem_ack && cnt >= lat)
      begin
         mem_ack   <= 1'b1;
         cnt       <= 0;
         mem_rdata <= m[mem_addr[9:2]];
         if (mem_we)
            m[mem_addr[9:2]] <= mem_wdata;
      end
      else
      begin
         mem_ack   <= 1'b0;
         cnt       <= mem_req ? cnt + 1 : 0;
         mem_rdata <= ~mem_rdata;
      end
   end
endmodule

// ### dv/tb_top.sv
/*
 Self-checking bench for the task unit with a word memory model.
 Assumes descriptors at table base 0, blocks at 0x100 and 0x200.
*/
`timescale 1ns/1ps
module tb_top;
   logic                clk = 1'b0;
   logic                nrst = 1'b0;
   logic                op_valid = 1'b0;
   tsk_pkg::tsk_op_e    op_kind = tsk_pkg::OP_STORE;
   tsk_pkg::tsk_cause_e op_cause = tsk_pkg::CS_CALL;
   logic [15:0]         op_sel = 16'h0000;
   logic [1:0]          current_privilege_level = 2'h0;
   logic [31:0]         gdt_base = 32'h0000_0000;
   logic [31:0]         ip = 32'h1234_5678;
   logic [31:0]         fl = 32'h0000_0246;
   logic [255:0]        gpr;
   logic [95:0]         seg;
   logic [3:0]          lat = 4'h0;
   logic                io_req = 1'b0;
   logic [15:0]         io_port = 16'h0000;
   logic                mem_req, mem_we, mem_ack, busy, done, fault_gp, fault_ts;
   logic                debug_trap, io_ack, io_deny, d, g, t, tr, ld_valid;
   logic [31:0]         mem_addr, mem_wdata, mem_rdata, page_root, ld_data;
   logic [6:0]          ld_off;
   int                  ld_n = 0;
   logic [15:0]         store_sel, current_task_selector, ldt_sel;
   int                  fail_count = 0;
   int                  n_checks = 0;

   always #50 clk = ~clk;

   // Loaded words counted at the edge after each pulse
   always @(posedge clk)
      if (ld_valid)
         ld_n++;

   tsk_task_unit dut_u (.clk, .nrst, .op_valid, .op_kind, .op_cause, .op_sel, .current_privilege_level,
      .gdt_base, .ctx_ip(ip), .ctx_flags(fl), .ctx_gpr(gpr), .ctx_seg(seg), .mem_req,
      .mem_we, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata, .ld_valid, .ld_off,
      .ld_data, .busy, .done, .fault_gp, .fault_ts, .debug_trap, .store_sel,
      .current_task_selector, .ldt_sel, .page_root, .io_req, .io_port, .io_ack,
      .io_deny);

   tsk_mem_model mem_u (.clk, .nrst, .lat, .mem_req, .mem_we, .mem_addr,
      .mem_wdata, .mem_ack, .mem_rdata);

   task automatic chk(input string n, input logic [31:0] a, input logic [31:0] e);
      n_checks++;
      if (a !== e)
      begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", n, e, a);
      end
   endtask

   // Issue one operation at a falling edge and wait for its outcome
   task automatic op(tsk_pkg::tsk_op_e k, tsk_pkg::tsk_cause_e c, logic [15:0] s,
                     logic [1:0] p);
      int i;
      op_kind  = k;
      op_cause = c;
      op_sel   = s;
      current_privilege_level      = p;
      op_valid = 1'b1;
      @(negedge clk);
      op_valid = 1'b0;
      for (i = 0; i < 400; i++)
      begin
         {d, g, t, tr} = {done, fault_gp, fault_ts, debug_trap};
         if (d | g | t)
            break;
         @(negedge clk);
      end
      if (!(d | g | t))
         fail_count++;
      chk("busy", busy, 32'h0000_0000);
   endtask

   function automatic logic [63:0] dsc(logic [31:0] b, logic [15:0] l, logic [1:0] p,
                                       logic [3:0] ty);
      return {b[31:24], 8'h00, 1'b1, p, 1'b0, ty, b[23:16], b[15:0], l};
   endfunction

   task automatic t_load();
      chk("reset sel", current_task_selector, 16'h0000);
      op(tsk_pkg::OP_LOAD, tsk_pkg::CS_CALL, 16'h000C, 2'h0);
      chk("load ti", {g, t}, 2'h2);
      op(tsk_pkg::OP_LOAD, tsk_pkg::CS_CALL, 16'h0008, 2'h1);
      chk("load cpl", {g, t}, 2'h2);
      op(tsk_pkg::OP_LOAD, tsk_pkg::CS_CALL, 16'h0008, 2'h0);
      chk("load", {d, current_task_selector}, 17'h1_0008);
      op(tsk_pkg::OP_STORE, tsk_pkg::CS_CALL, 16'h0000, 2'h3);
      chk("store", {d, store_sel}, 17'h1_0008);
      op(tsk_pkg::OP_SEGLD, tsk_pkg::CS_CALL, 16'h0010, 2'h0);
      chk("seg load", {g, t}, 2'h2);
      $display("test load/store done");
   endtask

   task automatic t_bad();
      logic [15:0] sl [5] = '{16'h0018, 16'h0020, 16'h0028, 16'h0014, 16'h000C};
      tsk_pkg::tsk_cause_e cs [5] = '{tsk_pkg::CS_CALL, tsk_pkg::CS_CALL,
         tsk_pkg::CS_JMP, tsk_pkg::CS_INTERRUPT_RETURN_OP, tsk_pkg::CS_JMP};
      logic [1:0] eg [5] = '{2'h2, 2'h2, 2'h1, 2'h1, 2'h2};
      for (int i = 0; i < 5; i++)
      begin
         op(tsk_pkg::OP_SWITCH, cs[i], sl[i], (i == 0) ? 2'h2 : 2'h0);
         chk("switch fault", {g, t}, eg[i]);
      end
      chk("sel kept", current_task_selector, 16'h0008);
      $display("test refused switches done");
   endtask

   task automatic t_switch();
      int i;
      int n0;
      lat = 4'h2;
      n0 = ld_n;
      op(tsk_pkg::OP_SWITCH, tsk_pkg::CS_CALL, 16'h0010, 2'h0);
      chk("done trap", {d, tr}, 2'h3);
      chk("last load", {ld_valid, ld_off}, 8'hE4);
      chk("trap word", ld_data, 32'h0068_0001);
      chk("ip", mem_u.m[72], ip);
      chk("flags", mem_u.m[73], fl);
      for (i = 0; i < 8; i++)
         chk("gpr", mem_u.m[74 + i], gpr[32 * i +: 32]);
      for (i = 0; i < 6; i++)
         chk("seg", mem_u.m[82 + i][15:0], seg[16 * i +: 16]);
      chk("stack ptr", mem_u.m[65], 32'hA500_0001);
      chk("ldt field", mem_u.m[88], 32'hA500_0018);
      chk("link", mem_u.m[128][15:0], 16'h0008);
      chk("new sel", current_task_selector, 16'h0010);
      chk("ldt sel", ldt_sel, 16'h0018);
      chk("page root", page_root, 32'hB000_0007);
      io_req = 1'b1;
      @(negedge clk);
      io_req = 1'b0;
      for (i = 0; i < 3 && io_ack !== 1'b1; i++)
         @(negedge clk);
      chk("io deny", {io_ack, io_deny}, 2'h3);
      chk("words loaded", ld_n - n0, 19);
      lat = 4'h0;
      op(tsk_pkg::OP_SWITCH, tsk_pkg::CS_JMP, 16'h0008, 2'h0);
      chk("jmp done", {d, tr}, 2'h2);
      chk("no link", mem_u.m[64], 32'hA500_0000);
      chk("ip back", mem_u.m[136], ip);
      chk("sel back", current_task_selector, 16'h0008);
      mem_u.m[128] = 32'h0000_0000;
      op(tsk_pkg::OP_SWITCH, tsk_pkg::CS_INTX, 16'h0010, 2'h3);
      chk("int link", {d, mem_u.m[128][15:0]}, 17'h1_0008);
      $display("test task switch done");
   endtask

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   initial
   begin
      for (int i = 0; i < 8; i++)
         gpr[32 * i +: 32] = 32'hC000_0000 + i;
      for (int i = 0; i < 6; i++)
         seg[16 * i +: 16] = 16'h0100 + 16'(i);
      for (int i = 0; i < 26; i++)
      begin
         mem_u.m[64 + i]  = 32'hA500_0000 + i;
         mem_u.m[128 + i] = 32'hB000_0000 + i;
      end
      mem_u.m[89]  = 32'h0068_0000;
      mem_u.m[153] = 32'h0068_0001;
      {mem_u.m[3], mem_u.m[2]}   = dsc(32'h0000_0100, 16'h0067, 2'h0, 4'h9);
      {mem_u.m[5], mem_u.m[4]}   = dsc(32'h0000_0200, 16'h0067, 2'h0, 4'h9);
      {mem_u.m[7], mem_u.m[6]}   = dsc(32'h0000_0200, 16'h0067, 2'h1, 4'h9);
      {mem_u.m[9], mem_u.m[8]}   = dsc(32'h0000_0200, 16'h0067, 2'h0, 4'hB);
      {mem_u.m[11], mem_u.m[10]} = dsc(32'h0000_0200, 16'h0060, 2'h0, 4'h9);
      repeat (10) @(negedge clk);
      nrst = 1'b1;
      t_load();
      t_bad();
      t_switch();
      wrap_up();
   end

   // Whole run needs a few hundred cycles; this leaves wide margin
   initial
   begin
      #1_000_000;
      fail_count++;
      wrap_up();
   end
endmodule
